/* swp_master.sv */
// Programming master end with its transaction FIFO
`timescale 1ns/1ps
`default_nettype none
module swp_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	input  wire logic             sys_clk_in,
	input  wire logic             reset_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q, wr_d;
	logic [AW-1:0]    rd_q, rd_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             rdy_q, rdy_d;
	logic             push;
	logic             pop;

	// Pointer and fill count update
	always_comb begin
		push = in_valid_in && rdy_q;
		pop = out_ready_in && (cnt_q != '0);
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		rdy_d = (cnt_d != (AW+1)'(DEPTH));
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b1;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			rdy_q <= rdy_d;
		end
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	assign in_ready_out = rdy_q;
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out = mem_q[rd_q];
endmodule

module swp_master #(
	parameter logic [swp_pkg::CW-1:0] BIT_CYC     = swp_pkg::BIT_CYCLES,
	parameter logic [swp_pkg::CW-1:0] HOLD_CYC    = swp_pkg::HOLD_CYCLES,
	parameter logic [swp_pkg::CW-1:0] TIMEOUT_CYC = swp_pkg::TIMEOUT_CYCLES
) (
	input  wire logic                        sys_clk_in,
	input  wire logic                        reset_in,
	swp_port_if.master                       port_io,
	input  wire logic                        cmd_valid_in,
	input  wire logic [swp_pkg::WORD_W-1:0]  cmd_word_in,
	output logic                             cmd_ready_out,
	output logic                             rd_valid_out,
	output logic [swp_pkg::DATA_W-1:0]       rd_data_out,
	output logic                             no_answer_out,
	output logic                             busy_out
);
	import swp_pkg::*;

	typedef enum logic [2:0] {
		M_HOLD   = 3'b000,
		M_IDLE   = 3'b001,
		M_START  = 3'b010,
		M_BITS   = 3'b011,
		M_LISTEN = 3'b100,
		M_TAKE   = 3'b101,
		M_STOP   = 3'b110
	} master_state_t;

	localparam logic [CW-1:0] QUARTER = BIT_CYC >> 2;
	localparam logic [CW-1:0] THREE_Q = BIT_CYC - QUARTER;

	logic                line_s1_q;
	logic                line_s2_q;
	logic                line_prev_q;
	logic                rise;
	logic                fall;
	master_state_t       state_q, state_d;
	logic [CW-1:0]       cnt_q, cnt_d;
	logic [CW-1:0]       hi_q, hi_d;
	logic [4:0]          idx_q, idx_d;
	logic [WORD_W-1:0]   sh_q, sh_d;
	logic                is_rd_q, is_rd_d;
	logic [DATA_W-1:0]   rd_sh_q, rd_sh_d;
	logic                rd_valid_q, rd_valid_d;
	logic                no_ans_q, no_ans_d;
	logic                busy_q, busy_d;
	logic                drv_q, drv_d;
	logic                oe_q, oe_d;
	logic                f_valid;
	logic [WORD_W-1:0]   f_data;
	logic                f_pop;

	swp_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) cmd_fifo (
		.sys_clk_in    (sys_clk_in),
		.reset_in      (reset_in),
		.in_valid_in   (cmd_valid_in),
		.in_data_in    (cmd_word_in),
		.in_ready_out  (cmd_ready_out),
		.out_valid_out (f_valid),
		.out_data_out  (f_data),
		.out_ready_in  (f_pop)
	);

	// Two-flop synchroniser on the shared pin, then an edge-detect stage
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			line_s1_q <= 1'b1;
			line_s2_q <= 1'b1;
			line_prev_q <= 1'b1;
		end else begin
			line_s1_q <= port_io.line;
			line_s2_q <= line_s1_q;
			line_prev_q <= line_s2_q;
		end
	end

	assign rise = line_s2_q & ~line_prev_q;
	assign fall = ~line_s2_q & line_prev_q;

	// Transaction sequencer; the FIFO drains only when idle
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q + 1'b1;
		hi_d = hi_q;
		idx_d = idx_q;
		sh_d = sh_q;
		is_rd_d = is_rd_q;
		rd_sh_d = rd_sh_q;
		rd_valid_d = 1'b0;
		no_ans_d = 1'b0;
		f_pop = 1'b0;
		oe_d = 1'b1;
		drv_d = 1'b1;
		case (state_q)
			M_HOLD: begin
				if (cnt_q == HOLD_CYC - 1'b1) begin // RULE3
					state_d = M_IDLE;
				end
			end
			M_IDLE: begin
				if (f_valid) begin // RULE6
					f_pop = 1'b1;
					is_rd_d = f_data[DATA_W];
					sh_d = f_data[DATA_W] ? {f_data[WORD_W-1:DATA_W], {DATA_W{1'b0}}} : f_data;
					state_d = M_START;
					cnt_d = '0;
					drv_d = 1'b0;
				end
			end
			M_START: begin
				drv_d = 1'b0; // RULE7 RULE16 RULE22
				if (cnt_q == START_CYCLES - 1'b1) begin
					state_d = M_BITS;
					cnt_d = '0;
					idx_d = '0;
				end
			end
			M_BITS: begin
				drv_d = (cnt_q < (sh_q[WORD_W-1] ? THREE_Q : QUARTER)); // RULE18 RULE21
				if (is_rd_q && idx_q == HANDOVER_IDX && cnt_q == THREE_Q - 1'b1) begin // RULE10
					state_d = M_LISTEN;
					cnt_d = '0;
					idx_d = '0;
				end else if (cnt_q == BIT_CYC - 1'b1) begin
					cnt_d = '0;
					idx_d = idx_q + 1'b1;
					sh_d = sh_q << 1; // RULE8 RULE9
					if (!is_rd_q && idx_q == WORD_LAST) begin // RULE11
						state_d = M_STOP;
					end
				end
			end
			M_LISTEN: begin
				oe_d = 1'b0;
				if (rise) begin
					cnt_d = '0;
					idx_d = idx_q + 1'b1;
					if (idx_q != 5'h00) begin
						rd_sh_d = {rd_sh_q[DATA_W-2:0], (hi_q > (BIT_CYC >> 1))};
					end
				end
				if (fall) begin
					hi_d = cnt_q;
					if (idx_q == RX_RISES) begin // RULE10
						state_d = M_TAKE;
						cnt_d = '0;
						oe_d = 1'b1;
						drv_d = 1'b0;
					end
				end
				if (cnt_q == TIMEOUT_CYC) begin
					state_d = M_STOP;
					cnt_d = '0;
					no_ans_d = 1'b1;
				end
			end
			M_TAKE: begin
				drv_d = 1'b0;
				if (cnt_q == QUARTER - 1'b1) begin // RULE11
					state_d = M_STOP;
					cnt_d = '0;
					rd_valid_d = 1'b1;
				end
			end
			M_STOP: begin
				if (cnt_q == STOP_CYCLES - 1'b1) begin // RULE17
					state_d = M_IDLE;
				end
			end
			default: begin
				state_d = M_IDLE;
			end
		endcase
		busy_d = (state_d != M_IDLE) || f_valid;
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			state_q <= M_HOLD;
			cnt_q <= '0;
			hi_q <= '0;
			idx_q <= '0;
			sh_q <= '0;
			is_rd_q <= 1'b0;
			rd_sh_q <= '0;
			rd_valid_q <= 1'b0;
			no_ans_q <= 1'b0;
			busy_q <= 1'b1;
			drv_q <= 1'b1;
			oe_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			hi_q <= hi_d;
			idx_q <= idx_d;
			sh_q <= sh_d;
			is_rd_q <= is_rd_d;
			rd_sh_q <= rd_sh_d;
			rd_valid_q <= rd_valid_d;
			no_ans_q <= no_ans_d;
			busy_q <= busy_d;
			drv_q <= drv_d;
			oe_q <= oe_d;
		end
	end

	assign port_io.m_drv = drv_q;
	assign port_io.m_oe = oe_q;
	assign rd_valid_out = rd_valid_q;
	assign rd_data_out = rd_sh_q;
	assign no_answer_out = no_ans_q;
	assign busy_out = busy_q;
endmodule
`default_nettype wire

/* swp_pkg.sv */
// Shared constants for the single-wire programming port
package swp_pkg;
	localparam int CW = 24;                           // Width of the master and slave time counters
	localparam int CLK_MHZ = 250;                     // System clock rate
	localparam int CMD_W = 8;                         // Command byte width
	localparam int ADDR_W = 7;                        // Address field of the command byte
	localparam int DATA_W = 16;                       // Two data bytes
	localparam int WORD_W = CMD_W + DATA_W;           // One write transaction
	localparam int DATA_BITS = 16;                    // Slave data bits in a read
	localparam int FIFO_DEPTH = 32;
	localparam int SYNC_LAT = 3;                      // Pin to edge-detect latency
	// Times in microseconds
	localparam int IDLE_TIMEOUT_US = 250;
	localparam int START_MIN_US = 5;
	localparam int STOP_MIN_US = 5;
	localparam int BIT_MIN_US = 10;
	localparam int BIT_MAX_US = 100;
	localparam int BIT_NOM_US = 20;                   // Period the master sends with
	localparam int TON_US = 2000;                     // Start-up delay
	localparam int ENTRY_US = 20000;                  // Command-mode entry slot
	// Cycle counts
	localparam logic [CW-1:0] TIMEOUT_CYCLES = CW'(IDLE_TIMEOUT_US * CLK_MHZ - SYNC_LAT - 1);
	localparam logic [CW-1:0] HOLD_CYCLES = CW'(IDLE_TIMEOUT_US * CLK_MHZ);
	localparam logic [CW-1:0] START_CYCLES = CW'(START_MIN_US * CLK_MHZ);
	localparam logic [CW-1:0] STOP_CYCLES = CW'(STOP_MIN_US * CLK_MHZ);
	localparam logic [CW-1:0] BIT_MIN_CYCLES = CW'(BIT_MIN_US * CLK_MHZ);
	localparam logic [CW-1:0] BIT_MAX_CYCLES = CW'(BIT_MAX_US * CLK_MHZ);
	localparam logic [CW-1:0] BIT_CYCLES = CW'(BIT_NOM_US * CLK_MHZ);
	localparam logic [CW-1:0] TON_CYCLES = CW'(TON_US * CLK_MHZ);
	localparam logic [CW-1:0] ENTRY_CYCLES = CW'(ENTRY_US * CLK_MHZ);
	// Entry transaction: address and signature values are arbitrary
	localparam logic [ADDR_W-1:0] ENTRY_ADDR = 7'h5a;
	localparam logic [DATA_W-1:0] ENTRY_SIGNATURE = 16'h1234;
	// Bit counts
	localparam logic [4:0] CMD_LAST = 5'h07;
	localparam logic [4:0] WORD_LAST = 5'h17;
	localparam logic [4:0] HANDOVER_IDX = 5'h08;
	localparam logic [4:0] TX_LAST = 5'h11;
	localparam logic [4:0] RX_RISES = 5'h11;
endpackage

/* swp_port_if.sv */
// Shared wire between programming master and sensor slave
`timescale 1ns/1ps
`default_nettype none
interface swp_port_if;
	logic m_drv;
	logic m_oe;
	logic s_drv;
	logic s_oe;
	logic line;
	// Master overdrives the slave; pull-up when nobody drives
	assign line = m_oe ? m_drv : (s_oe ? s_drv : 1'b1);
	modport master (output m_drv, output m_oe, input line);
	modport slave (output s_drv, output s_oe, input line);
endinterface
`default_nettype wire

/* swp_slave.sv */
// Sensor end of the single-wire programming port
//
// Summary of operation
// RULE1: After start-up delay, run analog or SENT output
// RULE2: Output mode chosen from stored configuration
// RULE3: Master holds pin high one timeout first
// RULE4: Entry accepted only in slot after power-on
// RULE5: Master overdrives the active output during entry
// RULE6: Sensor is always slave, programmer always master
// RULE7: Start is low level then rising edge
// RULE8: One command byte selects read or write
// RULE9: Data bytes follow the command without gap
// RULE10: Reads wrap data in handover/takeover bits
// RULE11: Stop is rising edge after low level
// RULE12: No rising edge for timeout: back to idle
// RULE13: Entry uses the ordinary transaction format
// RULE14: Command mode gives register and storage access
// RULE15: Only power-on reset leaves command mode
// RULE16: Start low level lasts at least start time
// RULE17: Stop high level lasts at least stop time
// RULE18: Long pulse is one, short pulse zero
// RULE19: Master rewrites checksum after storage changes
// RULE20: Communication reset within 250 us of last rise
// RULE21: Any bit period from 10 to 100 us
// RULE22: Start low level at least 5 us
// RULE23: Pulse longer than half period reads one
`timescale 1ns/1ps
`default_nettype none
module swp_slave #(
	parameter logic [swp_pkg::CW-1:0]     TIMEOUT_CYC = swp_pkg::TIMEOUT_CYCLES,
	parameter logic [swp_pkg::CW-1:0]     TON_CYC     = swp_pkg::TON_CYCLES,
	parameter logic [swp_pkg::CW-1:0]     ENTRY_CYC   = swp_pkg::ENTRY_CYCLES,
	parameter logic [swp_pkg::ADDR_W-1:0] ENTRY_ADDR  = swp_pkg::ENTRY_ADDR,
	parameter logic [swp_pkg::DATA_W-1:0] SIGNATURE   = swp_pkg::ENTRY_SIGNATURE
) (
	input  wire logic                        sys_clk_in,
	input  wire logic                        reset_in,
	swp_port_if.slave                        port_io,
	input  wire logic                        mode_sel_in,
	input  wire logic                        normal_level_in,
	input  wire logic [swp_pkg::DATA_W-1:0]  rd_data_in,
	output logic                             normal_active_out,
	output logic                             sent_mode_out,
	output logic                             cmd_mode_out,
	output logic                             wr_strobe_out,
	output logic                             timeout_out,
	output logic [swp_pkg::ADDR_W-1:0]       acc_addr_out,
	output logic [swp_pkg::DATA_W-1:0]       wr_data_out
);
	import swp_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_RX     = 3'b001,
		S_HOVER  = 3'b010,
		S_TX     = 3'b011,
		S_WSTOP  = 3'b100,
		S_IGNORE = 3'b101
	} slave_state_t;

	logic                line_s1_q;
	logic                line_s2_q;
	logic                line_prev_q;
	logic                rise;
	logic                fall;
	slave_state_t        state_q, state_d;
	logic [CW-1:0]       por_q, por_d;
	logic [CW-1:0]       since_q, since_d;
	logic [CW-1:0]       hi_q, hi_d;
	logic [CW-1:0]       period_q, period_d;
	logic [CW-1:0]       tx_cnt_q, tx_cnt_d;
	logic [CW-1:0]       quarter;
	logic [CW-1:0]       three_q;
	logic [4:0]          nbits_q, nbits_d;
	logic [4:0]          idx_q, idx_d;
	logic [WORD_W-1:0]   rx_q, rx_d;
	logic [DATA_W:0]     tx_sh_q, tx_sh_d;
	logic                cmd_mode_q, cmd_mode_d;
	logic                normal_q, normal_d;
	logic                sent_q, sent_d;
	logic                wr_strobe_q, wr_strobe_d;
	logic                timeout_q, timeout_d;
	logic [ADDR_W-1:0]   acc_addr_q, acc_addr_d;
	logic [DATA_W-1:0]   wr_data_q, wr_data_d;
	logic                drv_q, drv_d;
	logic                oe_q, oe_d;
	logic                bit_v;
	logic [WORD_W-1:0]   word_v;
	logic                entry_open;

	// Two-flop synchroniser on the shared pin, then an edge-detect stage
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			line_s1_q <= 1'b1;
			line_s2_q <= 1'b1;
			line_prev_q <= 1'b1;
		end else begin
			line_s1_q <= port_io.line;
			line_s2_q <= line_s1_q;
			line_prev_q <= line_s2_q;
		end
	end

	assign rise = line_s2_q & ~line_prev_q;
	assign fall = ~line_s2_q & line_prev_q;
	// Slave bit timing derived from the last measured master period
	assign quarter = period_q >> 2;
	assign three_q = period_q - quarter;
	assign entry_open = (por_q < ENTRY_CYC);

	// Receive, transmit and mode control
	always_comb begin
		state_d = state_q;
		nbits_d = nbits_q;
		idx_d = idx_q;
		rx_d = rx_q;
		tx_sh_d = tx_sh_q;
		period_d = period_q;
		acc_addr_d = acc_addr_q;
		wr_data_d = wr_data_q;
		cmd_mode_d = cmd_mode_q;
		wr_strobe_d = 1'b0;
		timeout_d = 1'b0;
		hi_d = hi_q;
		por_d = (por_q == {CW{1'b1}}) ? por_q : por_q + 1'b1;
		since_d = (since_q == TIMEOUT_CYC) ? since_q : since_q + 1'b1;
		tx_cnt_d = tx_cnt_q + 1'b1;
		if (rise) begin
			since_d = '0;
		end
		if (fall) begin
			hi_d = since_q;
		end
		// Period is free within limits; width compared to half of it
		bit_v = (hi_q > (since_q >> 1)); // RULE18 RULE21 RULE23
		word_v = {rx_q[WORD_W-2:0], bit_v};
		case (state_q)
			S_IDLE: begin
				if (rise) begin // RULE7 RULE6
					state_d = S_RX;
					nbits_d = '0;
				end
			end
			S_RX: begin
				if (rise) begin
					rx_d = word_v; // RULE9
					nbits_d = nbits_q + 1'b1;
					if (nbits_q == CMD_LAST && bit_v) begin // RULE8
						if (cmd_mode_q) begin // RULE14
							state_d = S_HOVER; // RULE10
							tx_cnt_d = '0;
							period_d = since_q + 1'b1; // Rise to rise, this edge counted
							acc_addr_d = word_v[CMD_W-1:1];
						end else begin
							state_d = S_IGNORE;
						end
					end else if (nbits_q == WORD_LAST) begin // RULE11
						state_d = S_IDLE;
						if (cmd_mode_q) begin // RULE14
							wr_strobe_d = 1'b1;
							acc_addr_d = word_v[WORD_W-1:DATA_W+1];
							wr_data_d = word_v[DATA_W-1:0];
						end else if (entry_open && !word_v[DATA_W] // RULE4 RULE13
							&& word_v[WORD_W-1:DATA_W+1] == ENTRY_ADDR
							&& word_v[DATA_W-1:0] == SIGNATURE) begin
							cmd_mode_d = 1'b1;
						end
					end
				end
			end
			S_HOVER: begin
				// Take over on the falling edge of the master handover bit
				if (fall) begin // RULE10
					state_d = S_TX;
					idx_d = '0;
					tx_sh_d = {rd_data_in, 1'b0};
				end
			end
			S_TX: begin
				if (tx_cnt_q == period_q - 1'b1) begin
					tx_cnt_d = '0;
					idx_d = idx_q + 1'b1;
					if (idx_q != 5'h00) begin
						tx_sh_d = tx_sh_q << 1;
					end
				end
				if (idx_q == TX_LAST && rise && tx_cnt_q > quarter) begin // RULE10 RULE11
					state_d = S_IDLE; // Master stop edge came before our release
				end else if (idx_q == TX_LAST && tx_cnt_q >= three_q) begin // RULE10
					state_d = S_WSTOP;
				end
			end
			S_WSTOP: begin
				if (rise) begin
					state_d = S_IDLE;
				end
			end
			default: begin
				state_d = state_q;
			end
		endcase
		// Abandon anything in progress once the line stays quiet
		if (state_q != S_IDLE && since_q == TIMEOUT_CYC && !rise) begin // RULE12 RULE20
			state_d = S_IDLE;
			timeout_d = 1'b1;
		end
		normal_d = (por_q >= TON_CYC) && !cmd_mode_d; // RULE1 RULE15
		sent_d = mode_sel_in; // RULE2
		// Pin: normal output, or own bits in a read, else released
		if (state_d == S_TX) begin
			oe_d = 1'b1;
			drv_d = (idx_d != 5'h00) && (tx_cnt_d < (tx_sh_d[DATA_W] ? three_q : quarter)); // RULE18
		end else begin
			oe_d = normal_d; // RULE5
			drv_d = normal_level_in;
		end
	end

	// State registers; command mode only cleared by power-on reset
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			state_q <= S_IDLE;
			por_q <= '0;
			since_q <= '0;
			hi_q <= '0;
			period_q <= '0;
			tx_cnt_q <= '0;
			nbits_q <= '0;
			idx_q <= '0;
			rx_q <= '0;
			tx_sh_q <= '0;
			cmd_mode_q <= 1'b0;
			normal_q <= 1'b0;
			sent_q <= 1'b0;
			wr_strobe_q <= 1'b0;
			timeout_q <= 1'b0;
			acc_addr_q <= '0;
			wr_data_q <= '0;
			drv_q <= 1'b1;
			oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			por_q <= por_d;
			since_q <= since_d;
			hi_q <= hi_d;
			period_q <= period_d;
			tx_cnt_q <= tx_cnt_d;
			nbits_q <= nbits_d;
			idx_q <= idx_d;
			rx_q <= rx_d;
			tx_sh_q <= tx_sh_d;
			cmd_mode_q <= cmd_mode_d; // RULE15
			normal_q <= normal_d;
			sent_q <= sent_d;
			wr_strobe_q <= wr_strobe_d;
			timeout_q <= timeout_d;
			acc_addr_q <= acc_addr_d;
			wr_data_q <= wr_data_d;
			drv_q <= drv_d;
			oe_q <= oe_d;
		end
	end

	assign port_io.s_drv = drv_q;
	assign port_io.s_oe = oe_q;
	assign normal_active_out = normal_q;
	assign sent_mode_out = sent_q;
	assign cmd_mode_out = cmd_mode_q;
	assign wr_strobe_out = wr_strobe_q;
	assign timeout_out = timeout_q;
	assign acc_addr_out = acc_addr_q;
	assign wr_data_out = wr_data_q;
endmodule
`default_nettype wire

/* swp_link_properties.sv */
// Wire-level checks of the single-wire programming port
`timescale 1ns/1ps
`default_nettype none
module swp_link_properties #(
	parameter int HOLD_CYC    = 400,
	parameter int TON_CYC     = 200,
	parameter int BIT_CYC     = 64,
	parameter int TIMEOUT_CYC = 400
) (
	input  wire logic sys_clk_in,
	input  wire logic reset_in,
	input  wire logic m_drv,
	input  wire logic m_oe,
	input  wire logic s_drv,
	input  wire logic s_oe,
	input  wire logic line
);
	import swp_pkg::*;
	localparam int PER_LO = BIT_CYC - 6;
	localparam int PER_HI = BIT_CYC + 6;
	logic [15:0] rc_q, hi_q, lo_q, per_q, sl_q, rc_d, hi_d, lo_d, per_d, sl_d;
	logic        ln_q;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	function automatic logic [15:0] inc(input logic [15:0] v);
		return (v == 16'hffff) ? v : v + 16'h0001;
	endfunction
	// Level run lengths, time since reset, time since the last rise
	always_comb begin
		rc_d  = inc(rc_q);
		hi_d  = line ? inc(hi_q) : 16'h0000;
		lo_d  = line ? 16'h0000 : inc(lo_q);
		per_d = (line && !ln_q) ? 16'h0001 : inc(per_q);
		sl_d  = (s_oe && !s_drv && !m_oe) ? inc(sl_q) : 16'h0000;
	end
	// Register the helper counters
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			{rc_q, hi_q, lo_q, per_q, sl_q} <= '0;
			ln_q <= 1'b1;
		end else begin
			{rc_q, hi_q, lo_q, per_q, sl_q} <= {rc_d, hi_d, lo_d, per_d, sl_d};
			ln_q <= line;
		end
	end
	chk_slave_reset_off: assert property (disable iff (1'b0) reset_in |=> !s_oe)
		else $error("slave drives the pin right after reset");
	chk_master_reset_high: assert property (disable iff (1'b0) reset_in |=> m_oe && m_drv)
		else $error("master not driving high after reset");
	chk_hold_high_span: assert property (rc_q < HOLD_CYC - 2 |-> m_oe && m_drv)
		else $error("master left the idle high level too early");
	chk_quiet_before_on: assert property (rc_q < TON_CYC |-> !s_oe)
		else $error("slave output active before start-up delay");
	chk_bit_pulse_width: assert property ($fell(line) && hi_q < BIT_CYC |->
		hi_q == BIT_CYC / 4 || hi_q == 3 * BIT_CYC / 4)
		else $error("high pulse width is neither short nor long");
	chk_slave_bit_period: assert property ($rose(line) && !m_oe && !$past(m_oe)
		&& per_q < 2 * BIT_CYC |-> per_q inside {[PER_LO:PER_HI]})
		else $error("slave bit period differs from the master period");
	chk_slave_low_bound: assert property (sl_q <= TIMEOUT_CYC + 8)
		else $error("slave held the line low past the timeout");
	chk_slave_takeover: assert property ($fell(m_oe) && !line |-> (!line) [*8])
		else $error("slave released the line during takeover");
	chk_start_low_len: assert property ($rose(line) && m_oe && lo_q > BIT_CYC
		|-> lo_q >= START_CYCLES)
		else $error("start low level too short");
endmodule
`default_nettype wire

/* one_wire_programming_slave_tb.sv */
// Self-checking bench for both ends of the single-wire programming port
`timescale 1ns/1ps
`default_nettype none
module one_wire_programming_slave_tb;
	import swp_pkg::*;
	localparam int TO  = 400;
	localparam int TON = 200;
	localparam int ENT = 16000;
	logic        clk = 1'b0, rst = 1'b1, rst_m = 1'b1, msel = 1'b0, level = 1'b0;
	logic        nact, sent, cmode, wstb, tout, cvalid = 1'b0, cready, rvalid, noans, busy;
	logic [6:0]  addr;
	logic [15:0] rd_in = '0, wdata, rdata, rd_last, exp_last;
	logic [23:0] cword = '0;
	logic [22:0] got_wr[$], exp_wr[$];
	logic [23:0] fq[$];
	int          err_total = 0, compares = 0, rd_cnt = 0, na_cnt = 0, to_cnt = 0;
	int          exp_rd = 0, exp_na = 0, cyc = 0, in_cmd = 0, w, t0, i;
	swp_port_if i_swp_port_if ();
	swp_slave #(.TIMEOUT_CYC(CW'(TO)), .TON_CYC(CW'(TON)), .ENTRY_CYC(CW'(ENT))) i_swp_slave (
		.sys_clk_in(clk), .reset_in(rst), .port_io(i_swp_port_if.slave), .mode_sel_in(msel),
		.normal_level_in(level), .rd_data_in(rd_in), .normal_active_out(nact),
		.sent_mode_out(sent), .cmd_mode_out(cmode), .wr_strobe_out(wstb), .timeout_out(tout),
		.acc_addr_out(addr), .wr_data_out(wdata));
	swp_master #(.BIT_CYC(CW'(64)), .HOLD_CYC(CW'(400)), .TIMEOUT_CYC(CW'(TO))) i_swp_master (
		.sys_clk_in(clk), .reset_in(rst_m), .port_io(i_swp_port_if.master), .cmd_valid_in(cvalid),
		.cmd_word_in(cword), .cmd_ready_out(cready), .rd_valid_out(rvalid), .rd_data_out(rdata),
		.no_answer_out(noans), .busy_out(busy));
	swp_link_properties #(.HOLD_CYC(400), .TON_CYC(TON), .BIT_CYC(64), .TIMEOUT_CYC(TO))
		i_swp_link_properties (.sys_clk_in(clk), .reset_in(rst), .m_drv(i_swp_port_if.m_drv),
		.m_oe(i_swp_port_if.m_oe), .s_drv(i_swp_port_if.s_drv), .s_oe(i_swp_port_if.s_oe),
		.line(i_swp_port_if.line));
	// Clock
	always #2 clk = ~clk;
	// Collect every result the two ends report, mid-cycle where outputs are settled
	always @(negedge clk) begin
		cyc <= rst ? 0 : cyc + 1;
		if (wstb === 1'b1) got_wr.push_back({addr, wdata});
		if (rvalid === 1'b1) begin
			rd_cnt++;
			rd_last = rdata;
		end
		if (noans === 1'b1) na_cnt++;
		if (tout === 1'b1) to_cnt++;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Push one transaction and predict its outcome
	task automatic push(input logic [7:0] cmd, input logic [15:0] dat);
		cword = {cmd, dat};
		cvalid = 1'b1;
		while (cready !== 1'b1) tick(1);
		tick(1);
		cvalid = 1'b0;
		tick(1);
		if (cmd[0] && in_cmd != 0) begin
			exp_rd++;
			exp_last = rd_in;
		end else if (cmd[0]) begin
			exp_na++;
		end else if (in_cmd != 0) begin
			exp_wr.push_back({cmd[7:1], dat});
		end else if (cmd == {ENTRY_ADDR, 1'b0} && dat == ENTRY_SIGNATURE && cyc + 4200 < ENT) begin
			in_cmd = 1;
		end
	endtask
	// Wait for the master to go idle, then compare with the model
	task automatic settle;
		w = 0;
		tick(2);
		while (busy !== 1'b0 && w < 30000) begin
			tick(1);
			w++;
		end
		tick(8);
		cmp_word(rd_cnt, exp_rd);
		cmp_word(na_cnt, exp_na);
		if (exp_rd > 0) cmp_word(rd_last, exp_last);
		cmp_word(got_wr.size(), exp_wr.size());
		while (got_wr.size() > 0 && exp_wr.size() > 0) cmp_word(got_wr.pop_front(), exp_wr.pop_front());
		cmp_flag(cmode, in_cmd != 0);
		cmp_flag(nact, in_cmd == 0);
	endtask
	task automatic print_verdict;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		print_verdict();
	end
	// Main sequence
	initial begin
		void'($urandom(65625));
		msel = 1'($urandom);
		tick(3);
		rst = 1'b0;
		rst_m = 1'b0;
		tick(TON - 2);
		cmp_flag(nact, 1'b0);
		cmp_flag(sent, msel);
		tick(6);
		cmp_flag(nact, 1'b1);
		cmp_flag(i_swp_port_if.line, 1'b1);
		level = 1'b1;
		rd_in = 16'($urandom);
		push({7'($urandom), 1'b1}, 16'h0000);
		settle();
		push({ENTRY_ADDR, 1'b0}, ENTRY_SIGNATURE ^ 16'h8000);
		settle();
		push({ENTRY_ADDR, 1'b0}, ENTRY_SIGNATURE);
		settle();
		for (i = 0; i < 3; i++) push({7'($urandom), 1'b0}, 16'($urandom));
		settle();
		for (i = 0; i < 2; i++) begin
			rd_in = 16'($urandom);
			push({7'($urandom), 1'b1}, 16'h0000);
			settle();
		end
		t0 = to_cnt;
		push({7'($urandom), 1'b0}, 16'($urandom));
		void'(exp_wr.pop_back());
		tick(int'(START_CYCLES) + 5 * 64);
		rst_m = 1'b1;
		tick(3);
		rst_m = 1'b0;
		w = 0;
		while (to_cnt == t0 && w < TO + 40) begin
			tick(1);
			w++;
		end
		cmp_flag(to_cnt > t0, 1'b1);
		settle();
		push({7'($urandom), 1'b0}, 16'($urandom));
		settle();
		// Fill the master's buffer during its hold time until it refuses
		rst_m = 1'b1;
		tick(3);
		rst_m = 1'b0;
		i = 0;
		cvalid = 1'b1;
		while (cready === 1'b1 && i < 40) begin
			cword = {7'($urandom), 1'b0, 16'($urandom)};
			fq.push_back(cword);
			tick(1);
			i++;
		end
		cword = 24'($urandom);
		tick(1);
		cvalid = 1'b0;
		cmp_word(i, FIFO_DEPTH);
		cmp_flag(cready, 1'b0);
		// Let two frames through, then flush the rest by a master reset in the stop time
		w = 0;
		while (got_wr.size() < 2 && w < 12000) begin
			tick(1);
			w++;
		end
		rst_m = 1'b1;
		tick(3);
		rst_m = 1'b0;
		for (i = 0; i < 2; i++) exp_wr.push_back({fq[i][23:17], fq[i][15:0]});
		settle();
		cmp_flag(busy, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
